// File: rtl/codec_pkg.sv
// constants, types and helpers shared by the codec digital path
//
// Summary of operation
// - decimated A/D sample optionally high-passed to register
// - high-pass is third-order IIR, corner near 270 Hz
// - high-pass disable bit resets zero, filter active
// - A/D output hard-limits to 0x7fff or 0x8000
// - host words latched into D/A register at 8 kHz
// - D/A path optional high-pass, same transfer function
// - sample-and-hold raises word rate five times
// - seventh-order IIR low-pass at 40 kHz, shared shape
// - output gain attenuates 0 to -45 dB, 3 dB
// - digital delta-sigma modulator emits 1-bit at 1 MHz
// - active bit resets zero, inactive stops clocks, transfers
// - source field routes mic or aux unless external gain
// - range bit picks 500 or 160 mVp with preamp
// - mute bit resets zero, zero means muted
// - mute multiplexer sits right after D/A input
// - oversampled rate is 125 times sample rate
// - sinc-cubic stage decimates stream by 25
// - low-pass stage decimates by five to 8 kHz
package codec_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int SAMPLE_HZ = 8_000;
    localparam int OS_RATIO = 125;
    localparam int OS_HZ = SAMPLE_HZ * OS_RATIO;
    localparam int OS_DIV = CLK_HZ / OS_HZ;
    localparam int SINC_DECIM = 25;
    localparam int LPF_DECIM = 5;

    // ****************************************
    // datapath widths and filter shape
    // ****************************************
    localparam int SW = 16;
    localparam int DW = 24;
    localparam int GUARD = 4;
    localparam int HPF_ORDER = 3;
    localparam int LPF_ORDER = 7;
    localparam int HPF_SHIFT = 3;
    localparam int LPF_SHIFT = 2;
    localparam int SINC_W = 18;
    localparam int GAIN_W = 17;
    localparam int MOD_W = 26;

    // ****************************************
    // register map and reset values
    // ****************************************
    localparam logic [7:0] CTRL0_OFS = 8'h00;
    localparam logic [7:0] CTRL3_OFS = 8'h04;
    localparam logic [7:0] ADC_OFS = 8'h08;
    localparam logic [7:0] DAC_OFS = 8'h0C;
    localparam int ACTIVE_BIT = 0;
    localparam int MUTE_BIT = 1;
    localparam int SRC_BIT = 2;
    localparam int RANGE_BIT = 3;
    localparam int GAIN_LSB = 4;
    localparam int HPD_BIT = 0;

    typedef struct packed {
        logic [3:0] output_gain_sel;
        logic input_range_sel;
        logic input_source_sel;
        logic mute;
        logic active;
    } ctrl0_t;

    localparam ctrl0_t CTRL0_RST = '0;
    localparam logic HPD_RST = 1'b0;

    // attenuation steps of 3 dB, unity = 2^16
    localparam logic [GAIN_W-1:0] GAIN_TAB [16] = '{
        17'h10000, 17'h0B53C, 17'h08000, 17'h05AC2, 17'h04000, 17'h02D6A,
        17'h02000, 17'h016C3, 17'h01000, 17'h00B53, 17'h00800, 17'h005AD,
        17'h00400, 17'h002D7, 17'h00200, 17'h0016C};

    // hard limit to the 16-bit two's complement range
    function automatic logic [SW-1:0] sat16(input logic signed [DW-1:0] v);
        if (v > DW'(32767)) begin
            return 16'h7FFF;
        end else if (v < -DW'(32768)) begin
            return 16'h8000;
        end else begin
            return v[SW-1:0];
        end
    endfunction

endpackage

// File: rtl/filter_section.sv
// first-order IIR section, high-pass or low-pass, advanced by a strobe
`timescale 1ns/1ps
`default_nettype none
module filter_section #(
    parameter bit HIGHPASS = 1'b0,
    parameter int SHIFT = 2
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic en, // rate strobe
    input wire logic signed [codec_pkg::DW-1:0] x, // section input
    output logic signed [codec_pkg::DW-1:0] y // section output, registered
);
    logic signed [codec_pkg::DW-1:0] y_ff, nxt_y, xPrev_ff, nxt_xPrev;

    // leaky differentiator or leaky integrator; wide words avoid wrap
    always_comb begin
        nxt_y = y_ff;
        nxt_xPrev = xPrev_ff;
        if (en) begin
            nxt_xPrev = x;
            if (HIGHPASS) begin
                nxt_y = x - xPrev_ff + y_ff - (y_ff >>> SHIFT);
            end else begin
                nxt_y = y_ff + ((x - y_ff) >>> SHIFT);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            y_ff <= '0;
            xPrev_ff <= '0;
        end else begin
            y_ff <= nxt_y;
            xPrev_ff <= nxt_xPrev;
        end
    end

    assign y = y_ff;
endmodule
`default_nettype wire

// File: rtl/dsm_modulator.sv
// second-order digital delta-sigma modulator, one-bit output
`timescale 1ns/1ps
`default_nettype none
module dsm_modulator (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic en, // oversampled strobe
    input wire logic signed [codec_pkg::SW-1:0] x, // held 40 kHz word
    output logic bitOut // one-bit stream, registered
);
    localparam logic signed [codec_pkg::MOD_W-1:0] FS = 26'sh0008000;
    logic signed [codec_pkg::MOD_W-1:0] int1_ff, int2_ff, nxt_int1, nxt_int2, fb, xs;
    logic bit_ff, nxt_bit;

    // two integrators with feedback shape quantisation noise upward
    always_comb begin
        xs = codec_pkg::MOD_W'(x);
        fb = bit_ff ? FS : -FS;
        nxt_int1 = int1_ff;
        nxt_int2 = int2_ff;
        nxt_bit = bit_ff;
        if (en) begin
            nxt_int1 = int1_ff + xs - fb;
            nxt_int2 = int2_ff + nxt_int1 - fb;
            nxt_bit = ~nxt_int2[codec_pkg::MOD_W-1];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int1_ff <= '0;
            int2_ff <= '0;
            bit_ff <= 1'b0;
        end else begin
            int1_ff <= nxt_int1;
            int2_ff <= nxt_int2;
            bit_ff <= nxt_bit;
        end
    end

    assign bitOut = bit_ff;
endmodule
`default_nettype wire

// File: rtl/voiceband_codec_digital_path.sv
// top of the codec digital path: apb control, a/d and d/a filter chains
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module voiceband_codec_digital_path (
    input wire logic clk, // 100 MHz system clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic adcModBit, // analog modulator one-bit stream
    input wire logic ext_gain_mode_pin, // external gain mode pin
    input wire logic [15:0] serial_data_in, // host d/a word
    input wire logic dacWordValid, // host d/a word strobe
    output logic [15:0] adcSample, // a/d sample register
    output logic adcSampleValid, // one-cycle pulse per a/d sample
    output logic dacBit, // one-bit stream to analog d/a
    output logic preampAuxSel, // 1 routes aux_input to preamp
    output logic preampLowRange, // 1 selects 160 mVp range
    output logic analogBiasEn // analog bias and modulator enable
);
    // ****************************************
    // register file over apb
    // ****************************************
    codec_pkg::ctrl0_t ctrl0_ff, nxt_ctrl0;
    logic hpDisable_ff, nxt_hpDisable;
    logic [15:0] dacLatch_ff, nxt_dacLatch;
    logic [15:0] adcSample_ff, nxt_adcSample;
    logic wrEn, mapped;

    assign mapped = (paddr == codec_pkg::CTRL0_OFS) || (paddr == codec_pkg::CTRL3_OFS) ||
                    (paddr == codec_pkg::ADC_OFS) || (paddr == codec_pkg::DAC_OFS);
    assign wrEn = psel && penable && pwrite;
    assign pready = 1'b1; // zero wait states
    assign pslverr = psel && penable && !mapped;

    // control writes; reset leaves inactive, muted, high-pass on
    always_comb begin
        nxt_ctrl0 = ctrl0_ff;
        nxt_hpDisable = hpDisable_ff;
        if (wrEn && paddr == codec_pkg::CTRL0_OFS) begin
            nxt_ctrl0 = codec_pkg::ctrl0_t'(pwdata[7:0]);
        end
        if (wrEn && paddr == codec_pkg::CTRL3_OFS) begin
            nxt_hpDisable = pwdata[codec_pkg::HPD_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl0_ff <= codec_pkg::CTRL0_RST;
            hpDisable_ff <= codec_pkg::HPD_RST;
        end else begin
            ctrl0_ff <= nxt_ctrl0;
            hpDisable_ff <= nxt_hpDisable;
        end
    end

    // read mux, unused upper bits read zero
    always_comb begin
        prdata = 32'h00000000;
        case (paddr)
            codec_pkg::CTRL0_OFS: prdata = {24'h000000, ctrl0_ff};
            codec_pkg::CTRL3_OFS: prdata = {31'h00000000, hpDisable_ff};
            codec_pkg::ADC_OFS: prdata = {16'h0000, adcSample_ff};
            codec_pkg::DAC_OFS: prdata = {16'h0000, dacLatch_ff};
            default: prdata = 32'h00000000;
        endcase
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] modSync_ff, egSync_ff;
    logic modBit_ff, nxt_modBit, extGain_ff, nxt_extGain;

    // a change counts only once stages two and three agree
    always_comb begin
        nxt_modBit = (modSync_ff[1] == modSync_ff[2]) ? modSync_ff[2] : modBit_ff;
        nxt_extGain = (egSync_ff[1] == egSync_ff[2]) ? egSync_ff[2] : extGain_ff;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            modSync_ff <= 3'h0;
            egSync_ff <= 3'h0;
            modBit_ff <= 1'b0;
            extGain_ff <= 1'b0;
        end else begin
            modSync_ff <= {modSync_ff[1:0], adcModBit};
            egSync_ff <= {egSync_ff[1:0], ext_gain_mode_pin};
            modBit_ff <= nxt_modBit;
            extGain_ff <= nxt_extGain;
        end
    end

    // input routing is only meaningful with the preamp in use
    assign preampAuxSel = !extGain_ff && ctrl0_ff.input_source_sel;
    assign preampLowRange = !extGain_ff && ctrl0_ff.input_range_sel;
    assign analogBiasEn = ctrl0_ff.active;

    // ****************************************
    // rate strobes
    // ****************************************
    logic [6:0] osCnt_ff, nxt_osCnt;
    logic [4:0] midCnt_ff, nxt_midCnt;
    logic [2:0] smpCnt_ff, nxt_smpCnt;
    logic osTick, midTick, smpTick;

    // counters freeze while inactive so no stage advances
    assign osTick = ctrl0_ff.active && (osCnt_ff == 7'(codec_pkg::OS_DIV - 1));
    assign midTick = osTick && (midCnt_ff == 5'(codec_pkg::SINC_DECIM - 1));
    assign smpTick = midTick && (smpCnt_ff == 3'(codec_pkg::LPF_DECIM - 1));

    always_comb begin
        nxt_osCnt = osCnt_ff;
        nxt_midCnt = midCnt_ff;
        nxt_smpCnt = smpCnt_ff;
        if (ctrl0_ff.active) begin
            nxt_osCnt = osTick ? 7'h00 : osCnt_ff + 7'h01;
        end
        if (osTick) begin
            nxt_midCnt = midTick ? 5'h00 : midCnt_ff + 5'h01;
        end
        if (midTick) begin
            nxt_smpCnt = smpTick ? 3'h0 : smpCnt_ff + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            osCnt_ff <= 7'h00;
            midCnt_ff <= 5'h00;
            smpCnt_ff <= 3'h0;
        end else begin
            osCnt_ff <= nxt_osCnt;
            midCnt_ff <= nxt_midCnt;
            smpCnt_ff <= nxt_smpCnt;
        end
    end

    // ****************************************
    // a/d path: sinc-cubic decimator
    // ****************************************
    typedef logic signed [codec_pkg::SINC_W-1:0] sinc_t;
    sinc_t integ_ff [3], nxt_integ [3], combDly_ff [3], nxt_combDly [3];
    sinc_t combOut_ff, nxt_combOut, c1, c2, c3;

    // integrators wrap by design; combs undo it exactly
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            nxt_integ[i] = integ_ff[i];
            nxt_combDly[i] = combDly_ff[i];
        end
        nxt_combOut = combOut_ff;
        c1 = integ_ff[2] - combDly_ff[0];
        c2 = c1 - combDly_ff[1];
        c3 = c2 - combDly_ff[2];
        if (osTick) begin
            nxt_integ[0] = integ_ff[0] + (modBit_ff ? sinc_t'(1) : -sinc_t'(1));
            nxt_integ[1] = integ_ff[1] + integ_ff[0];
            nxt_integ[2] = integ_ff[2] + integ_ff[1];
        end
        if (midTick) begin
            nxt_combDly[0] = integ_ff[2];
            nxt_combDly[1] = c1;
            nxt_combDly[2] = c2;
            nxt_combOut = c3;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 3; i++) begin
                integ_ff[i] <= '0;
                combDly_ff[i] <= '0;
            end
            combOut_ff <= '0;
        end else begin
            integ_ff <= nxt_integ;
            combDly_ff <= nxt_combDly;
            combOut_ff <= nxt_combOut;
        end
    end

    // ****************************************
    // filter chains: low-pass at 40 kHz, high-pass at 8 kHz
    // ****************************************
    logic signed [codec_pkg::DW-1:0] adLp [codec_pkg::LPF_ORDER+1];
    logic signed [codec_pkg::DW-1:0] daLp [codec_pkg::LPF_ORDER+1];
    logic signed [codec_pkg::DW-1:0] adHp [codec_pkg::HPF_ORDER+1];
    logic signed [codec_pkg::DW-1:0] daHp [codec_pkg::HPF_ORDER+1];

    // sinc gain 25^3 scaled by two fills the 16-bit range
    assign adLp[0] = codec_pkg::DW'(combOut_ff) <<< 1;
    assign daHp[0] = codec_pkg::DW'($signed(dacLatch_ff));

    // same section shapes on both paths give identical responses
    for (genvar i = 0; i < codec_pkg::LPF_ORDER; i++) begin : g_lpf
        filter_section #(.HIGHPASS(1'b0), .SHIFT(codec_pkg::LPF_SHIFT)) adLpSec (
            .clk(clk), .sys_rst(sys_rst), .en(midTick), .x(adLp[i]), .y(adLp[i+1]));
        filter_section #(.HIGHPASS(1'b0), .SHIFT(codec_pkg::LPF_SHIFT)) daLpSec (
            .clk(clk), .sys_rst(sys_rst), .en(midTick), .x(daLp[i]), .y(daLp[i+1]));
    end
    for (genvar i = 0; i < codec_pkg::HPF_ORDER; i++) begin : g_hpf
        filter_section #(.HIGHPASS(1'b1), .SHIFT(codec_pkg::HPF_SHIFT)) adHpSec (
            .clk(clk), .sys_rst(sys_rst), .en(smpTick), .x(adHp[i]), .y(adHp[i+1]));
        filter_section #(.HIGHPASS(1'b1), .SHIFT(codec_pkg::HPF_SHIFT)) daHpSec (
            .clk(clk), .sys_rst(sys_rst), .en(smpTick), .x(daHp[i]), .y(daHp[i+1]));
    end

    // decimation by five: a/d high-pass sees the held low-pass output
    assign adHp[0] = adLp[codec_pkg::LPF_ORDER];

    // ****************************************
    // a/d output register with saturation
    // ****************************************
    logic signed [codec_pkg::DW-1:0] adPre;
    logic adValid_ff, nxt_adValid;

    // only this final step clips, so inner overflow never wraps
    assign adPre = hpDisable_ff ? adLp[codec_pkg::LPF_ORDER] : adHp[codec_pkg::HPF_ORDER];
    always_comb begin
        nxt_adcSample = adcSample_ff;
        nxt_adValid = 1'b0;
        if (smpTick) begin
            nxt_adcSample = codec_pkg::sat16(adPre);
            nxt_adValid = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            adcSample_ff <= 16'h0000;
            adValid_ff <= 1'b0;
        end else begin
            adcSample_ff <= nxt_adcSample;
            adValid_ff <= nxt_adValid;
        end
    end

    assign adcSample = adcSample_ff;
    assign adcSampleValid = adValid_ff;

    // ****************************************
    // d/a input latch, mute, hold, gain
    // ****************************************
    logic [15:0] dacPend_ff, nxt_dacPend;
    logic signed [codec_pkg::DW-1:0] daHold;
    logic signed [codec_pkg::DW+codec_pkg::GAIN_W:0] gainProd;
    logic signed [codec_pkg::SW-1:0] gainOut_ff, nxt_gainOut;

    // words are taken any time but enter the path only at 8 kHz;
    // transfers are refused while inactive
    always_comb begin
        nxt_dacPend = dacPend_ff;
        nxt_dacLatch = dacLatch_ff;
        if (dacWordValid && ctrl0_ff.active) begin
            nxt_dacPend = serial_data_in;
        end
        if (smpTick) begin
            nxt_dacLatch = ctrl0_ff.mute ? dacPend_ff : 16'h0000;
        end
    end

    // the hold register repeats each high-passed word five times
    assign daHold = hpDisable_ff ? daHp[0] : daHp[codec_pkg::HPF_ORDER];
    assign daLp[0] = daHold;

    // attenuation table in 3 dB steps, then clip for the modulator
    assign gainProd = daLp[codec_pkg::LPF_ORDER] *
                      $signed({1'b0, codec_pkg::GAIN_TAB[ctrl0_ff.output_gain_sel]});
    always_comb begin
        nxt_gainOut = gainOut_ff;
        if (midTick) begin
            nxt_gainOut = codec_pkg::sat16(codec_pkg::DW'(gainProd >>> 16));
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dacPend_ff <= 16'h0000;
            dacLatch_ff <= 16'h0000;
            gainOut_ff <= 16'h0000;
        end else begin
            dacPend_ff <= nxt_dacPend;
            dacLatch_ff <= nxt_dacLatch;
            gainOut_ff <= nxt_gainOut;
        end
    end

    // held 40 kHz word is resampled at 1 MHz by the modulator
    dsm_modulator modulator (
        .clk(clk),
        .sys_rst(sys_rst),
        .en(osTick),
        .x(gainOut_ff),
        .bitOut(dacBit)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // valid follows the strobe by one cycle and lasts exactly one
    sequence s_sampleTick;
        smpTick ##1 adValid_ff ##1 !adValid_ff;
    endsequence

    ctrl_reset_a: assert property ($past(sys_rst) |-> !ctrl0_ff.active && !ctrl0_ff.mute
        && !hpDisable_ff) else $error("control defaults wrong after reset");
    idle_strobe_a: assert property (!ctrl0_ff.active |->
        (!osTick && !midTick && !smpTick) ##1 $stable(osCnt_ff))
        else $error("strobe or counter moved while inactive");
    tick_nest_a: assert property (smpTick |-> midTick && osTick)
        else $error("sample strobe not aligned");
    os_spacing_a: assert property (osTick |=> !osTick [*8])
        else $error("oversampled strobes too close");
    ad_valid_a: assert property (smpTick |-> s_sampleTick)
        else $error("a/d valid missing or too long");
    ad_sat_a: assert property (smpTick && adPre > 24'sd32767
        |=> adcSample_ff == 16'h7FFF) else $error("a/d did not clip high");
    ad_satlow_a: assert property (smpTick && adPre < -24'sd32768
        |=> adcSample_ff == 16'h8000) else $error("a/d did not clip low");
    mute_zero_a: assert property (smpTick && !ctrl0_ff.mute |=> dacLatch_ff == 16'h0000)
        else $error("muted word entered path");
    ext_gain_a: assert property (extGain_ff |-> !preampAuxSel && !preampLowRange)
        else $error("preamp setting leaked in external gain");
    apb_err_a: assert property (psel && penable && !mapped |-> pslverr && pready)
        else $error("unmapped access not flagged");
endmodule
`default_nettype wire

// File: testbench/far_side_model.sv
// far-side model: analog modulator stream and host word source
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
    input wire logic clk, // system clock
    input wire logic level, // modulator density, all ones or all zeros
    input wire logic sendReq, // ask for one host word
    input wire logic [15:0] wordReq, // word to send
    output logic adcModBit, // modulator bit to the codec
    output logic [15:0] serial_data_in, // host word
    output logic dacWordValid // one-cycle word strobe
);
    // ****************************************
    // drive right after each edge
    // ****************************************
    // idle data is inverted so a stale word never passes for a fresh one
    always @(posedge clk) begin
        adcModBit <= level;
        dacWordValid <= sendReq;
        serial_data_in <= sendReq ? wordReq : ~serial_data_in;
    end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the codec digital path
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic level = 1'h1;
    logic sendReq = 1'h0;
    logic ext = 1'h0;
    logic [15:0] wordReq = 16'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, modBit, wordValid, adcSampleValid, dacBit, dPrev, aux, low, bias;
    logic [15:0] sdi, adcSample, w;
    logic [3:0] g;
    int badCount = 0;
    int checked = 0;
    int nValid = 0;
    int gap = 0;
    int nToggle = 0;

    always #5 clk = ~clk;

    voiceband_codec_digital_path voiceband_codec_digital_path_inst (.clk(clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .adcModBit(modBit),
        .ext_gain_mode_pin(ext), .serial_data_in(sdi), .dacWordValid(wordValid),
        .adcSample(adcSample), .adcSampleValid(adcSampleValid), .dacBit(dacBit),
        .preampAuxSel(aux), .preampLowRange(low), .analogBiasEn(bias));
    far_side_model far_side_model_inst (.clk(clk), .level(level), .sendReq(sendReq),
        .wordReq(wordReq), .adcModBit(modBit), .serial_data_in(sdi), .dacWordValid(wordValid));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            badCount++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // preamp controls only count while the preamp is in use
    function automatic logic selExp(input logic f, input logic e);
        return f & ~e;
    endfunction
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic waitSmp();
        do begin
            @(posedge clk);
        end while (adcSampleValid !== 1'h1);
    endtask
    task automatic sendWord(input logic [15:0] v);
        @(posedge clk);
        sendReq <= 1'h1;
        wordReq <= v;
        @(posedge clk);
        sendReq <= 1'h0;
    endtask
    task automatic endSim();
        $display("mismatches %0d of %0d checks", badCount, checked);
        if (badCount == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // sample spacing and sign; a wrap under full-scale ones would flip the sign
    always @(posedge clk) begin
        dPrev <= dacBit;
        if (dacBit === 1'h1 && dPrev === 1'h0) begin
            nToggle <= nToggle + 1;
        end
        if (adcSampleValid === 1'h1) begin
            if (nValid > 0) begin
                check("gap", gap, codec_pkg::OS_DIV * codec_pkg::SINC_DECIM * codec_pkg::LPF_DECIM);
            end
            check("sign", adcSample[15], 32'h0);
            nValid <= nValid + 1;
            gap <= 1;
        end else begin
            gap <= gap + 1;
        end
    end

    // hang guard, a little past the expected run length
    initial begin
        #1_000_000;
        badCount++;
        endSim();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        void'($urandom(93));
        repeat (12) @(posedge clk);
        sys_rst <= 1'h0;
        apb(1'h0, codec_pkg::CTRL0_OFS, 32'h0);
        check("ctrl0", rd, 32'h0);
        apb(1'h0, codec_pkg::CTRL3_OFS, 32'h0);
        check("ctrl3", rd, 32'h0);
        check("bias", bias, 32'h0);
        apb(1'h0, 8'h10, 32'h0);
        check("unmapped", er, 32'h1);
        apb(1'h1, codec_pkg::CTRL3_OFS, 32'h1);
        apb(1'h0, codec_pkg::CTRL3_OFS, 32'h0);
        check("ctrl3", rd, 32'h1);
        for (int i = 0; i < 8; i++) begin
            g = 4'($urandom);
            ext <= i[2];
            apb(1'h1, codec_pkg::CTRL0_OFS, {24'h0, g, i[1], i[0], 2'h0});
            apb(1'h0, codec_pkg::CTRL0_OFS, 32'h0);
            check("ctrl0", rd, {24'h0, g, i[1], i[0], 2'h0});
            repeat (5) @(posedge clk);
            check("aux", aux, selExp(i[0], i[2]));
            check("range", low, selExp(i[1], i[2]));
        end
        ext <= 1'h0;
        repeat (1000) @(posedge clk);
        check("idle", nValid, 32'h0);
        apb(1'h1, codec_pkg::CTRL0_OFS, {24'h0, g, 4'h1});
        // no analog settling in this model, so the first sample is trusted
        waitSmp();
        check("bias", bias, 32'h1);
        sendWord(16'($urandom) | 16'h4000);
        waitSmp();
        apb(1'h0, codec_pkg::DAC_OFS, 32'h0);
        check("muted", rd, 32'h0);
        apb(1'h1, codec_pkg::CTRL0_OFS, {24'h0, g, 4'h3});
        w = 16'($urandom) | 16'h4000;
        sendWord(w);
        waitSmp();
        apb(1'h0, codec_pkg::DAC_OFS, 32'h0);
        check("dac", rd, {16'h0, w});
        repeat (4) waitSmp();
        check("level", 32'(adcSample > 16'h2000), 32'h1);
        check("toggles", 32'(nToggle > 0), 32'h1);
        endSim();
    end
endmodule
`default_nettype wire
